// ---- hdl/cbt_pkg.sv ----
package cbt_pkg;

  // register byte offsets
  localparam logic [7:0] CBT_ADDR_CFG_ONE = 8'h00;
  localparam logic [7:0] CBT_ADDR_CFG_TWO = 8'h04;
  localparam logic [7:0] CBT_ADDR_STATUS = 8'h08;

  // bit_timing_cfg_one fields
  localparam int CBT_PRESCALE_LSB = 0;
  localparam int CBT_PRESCALE_W = 6;
  localparam int CBT_SJW_LSB = 6;
  localparam int CBT_CLKSEL_BIT = 8;

  // bit_timing_cfg_two fields
  localparam int CBT_PROP_LSB = 0;
  localparam int CBT_PH1_LSB = 3;
  localparam int CBT_TRIPLE_BIT = 6;
  localparam int CBT_PH2FREE_BIT = 7;
  localparam int CBT_PH2_LSB = 8;

  // status fields
  localparam int CBT_ST_SEG_LSB = 0;
  localparam int CBT_ST_BIT = 2;
  localparam int CBT_ST_HARD = 3;
  localparam int CBT_ST_RESYNC = 4;
  localparam int CBT_ST_LEN_LSB = 8;

  // reset values: 1 + 2 + 3 + 2 quanta, phase2 taken from its own field
  localparam logic [31:0] CBT_CFG_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] CBT_CFG_TWO_RST = 32'h0000_0191;

  // last pclk count of an instruction cycle; an instruction cycle spans four of them
  localparam logic [1:0] CBT_ICLK_LAST = 2'h3;

  // bit timing limits in quanta
  localparam logic [4:0] CBT_MIN_BIT_TQ = 5'h08;
  localparam logic [4:0] CBT_MAX_BIT_TQ = 5'h19;
  localparam logic [4:0] CBT_PROC_TQ = 5'h02;
  localparam logic [4:0] CBT_SYNC_TQ = 5'h01;

  // segment of the nominal bit
  typedef enum logic [1:0]
  {
    CBT_SEG_SYNC = 2'b00,
    CBT_SEG_PROP = 2'b01,
    CBT_SEG_PH1 = 2'b10,
    CBT_SEG_PH2 = 2'b11
  } cbt_seg_t;

  // a length field holds quanta minus one
  function automatic logic [4:0] cbt_field_len(input logic [2:0] f);
    cbt_field_len = {2'b00, f} + 5'h01;
  endfunction : cbt_field_len

  function automatic logic [4:0] cbt_max5(input logic [4:0] a,
                                          input logic [4:0] b);
    cbt_max5 = (a > b) ? a : b;
  endfunction : cbt_max5

  function automatic logic [4:0] cbt_min5(input logic [4:0] a,
                                          input logic [4:0] b);
    cbt_min5 = (a < b) ? a : b;
  endfunction : cbt_min5

endpackage : cbt_pkg

// ---- hdl/cbt_quantum_gen.sv ----
module cbt_quantum_gen
  import cbt_pkg::*;
#(
  parameter int PRESCALE_W = CBT_PRESCALE_W
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire logic module_clock_select,
  input wire logic [PRESCALE_W-1:0] quantum_prescale,
  // realignment
  input wire logic restart,
  // ticks
  output logic half_tick,
  output logic tq_tick
);

  logic [1:0] icnt;
  logic [PRESCALE_W-1:0] pcnt;
  logic phase;

  // module_input_clock: instruction clock when selected, else the full rate
  wire module_tick = module_clock_select ?
                     (icnt == CBT_ICLK_LAST) : 1'b1;
  // prescaler of 1..64 gives a half quantum, the phase flop the divide by two
  wire half_end = module_tick && (pcnt == quantum_prescale);
  wire [1:0] next_icnt = restart ? 2'h0 : icnt + 2'h1;
  wire [PRESCALE_W-1:0] next_pcnt = (restart || half_end) ? '0 :
                                    module_tick ? pcnt + 1'b1 : pcnt;
  wire next_phase = restart ? 1'b0 : half_end ? !phase : phase;

  // tq = 2 * (prescale + 1) module clocks; restart drops a pending tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      icnt <= 2'h0;
      pcnt <= '0;
      phase <= 1'b0;
      half_tick <= 1'b0;
      tq_tick <= 1'b0;
    end
    else
    begin
      icnt <= next_icnt;
      pcnt <= next_pcnt;
      phase <= next_phase;
      half_tick <= half_end && !restart;
      tq_tick <= half_end && phase && !restart;
    end
  end

endmodule : cbt_quantum_gen

// ---- hdl/cbt_sample_vote.sv ----
module cbt_sample_vote
  import cbt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timing
  input wire logic half_tick,
  input wire logic sample_now,
  input wire logic triple_sample_sel,
  // bus
  input wire logic can_rx,
  // result
  output logic bit_value,
  output logic bit_valid
);

  logic [1:0] hist;

  function automatic logic cbt_vote(input logic a, input logic b,
                                    input logic c);
    cbt_vote = (a & b) | (a & c) | (b & c);
  endfunction : cbt_vote

  // hist holds the levels half a quantum and a whole quantum back
  wire voted = cbt_vote(can_rx, hist[0], hist[1]);
  wire next_value = triple_sample_sel ? voted : can_rx;

  // history starts recessive so a first vote is not biased dominant
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist <= 2'b11;
      bit_value <= 1'b1;
      bit_valid <= 1'b0;
    end
    else
    begin
      if (half_tick)
        hist <= {hist[0], can_rx};
      if (sample_now)
        bit_value <= next_value;
      bit_valid <= sample_now;
    end
  end

  a_single_sample: assert property (@(posedge pclk) disable iff (!presetn)
    bit_valid && !$past(triple_sample_sel) |-> bit_value == $past(can_rx))
    else $error("single sample does not follow the bus level");

endmodule : cbt_sample_vote

// ---- hdl/cbt_bit_timing.sv ----
// Contract
// - nominal bit spans 8 to 25 whole quanta
// - quantum comes from a 1..64 prescaler then a divide by two
// - quantum lasts 2*(prescale+1) module input clocks
// - module clock is instruction clock if selected, else four times it
// - propagation segment 1..8 quanta from cfg two bits 2:0
// - phase1 1..8 quanta from cfg two bits 5:3
// - phase2 from bits 10:8, or max of phase1 and 2 quanta
// - bus level is sampled at the end of phase1
// - triple sample votes over three samples half a quantum apart
// - segments run sync, propagation, phase1, phase2 in order
// - hard sync only on a falling edge while the bus is idle
// - hard sync restarts the bit counters at the sync segment
// - no resync in a bit that had a hard sync
// - data edges compare to sync position and adjust the phases
// - resync moves phases by at most the 1..4 quantum jump width
module cbt_bit_timing
  import cbt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can bus and protocol engine
  input wire logic can_rx,
  input wire logic bus_idle,
  // bit timing events
  output logic tq_tick,
  output logic bit_start,
  output logic sample_point,
  output logic hard_synced,
  output logic bit_value,
  output logic bit_valid
);

  logic [31:0] bit_timing_cfg_one;
  logic [31:0] bit_timing_cfg_two;
  cbt_seg_t seg;
  logic [4:0] cnt;
  logic [4:0] pos;
  logic [4:0] ext;
  logic [4:0] cut;
  logic hard_flag;
  logic resync_done;
  logic prev_rx;
  logic half_tick;

  // apb decode; zero wait states, unmapped offsets answer with an error
  wire hit_one = (paddr == CBT_ADDR_CFG_ONE);
  wire hit_two = (paddr == CBT_ADDR_CFG_TWO);
  wire hit_st = (paddr == CBT_ADDR_STATUS);
  wire hit_any = hit_one || hit_two || hit_st;
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire wr_one = apb_access && pwrite && hit_one;
  wire wr_two = apb_access && pwrite && hit_two;
  assign pready = 1'b1;
  assign pslverr = apb_access && !hit_any;

  // configuration fields
  wire [5:0] quantum_prescale =
    bit_timing_cfg_one[CBT_PRESCALE_LSB +: CBT_PRESCALE_W];
  wire [1:0] sync_jump_width = bit_timing_cfg_one[CBT_SJW_LSB +: 2];
  wire module_clock_select = bit_timing_cfg_one[CBT_CLKSEL_BIT];
  wire [2:0] prop_seg_len = bit_timing_cfg_two[CBT_PROP_LSB +: 3];
  wire [2:0] phase1_len = bit_timing_cfg_two[CBT_PH1_LSB +: 3];
  wire [2:0] phase2_len = bit_timing_cfg_two[CBT_PH2_LSB +: 3];
  wire triple_sample_sel = bit_timing_cfg_two[CBT_TRIPLE_BIT];
  wire phase2_free_sel = bit_timing_cfg_two[CBT_PH2FREE_BIT];

  // segment lengths in quanta
  wire [4:0] prop_tq = cbt_field_len(prop_seg_len);
  wire [4:0] ph1_tq = cbt_field_len(phase1_len);
  wire [4:0] sjw_tq = cbt_field_len({1'b0, sync_jump_width});
  // phase2 either from its field or from phase1 and the processing time
  wire [4:0] ph2_base = phase2_free_sel ? cbt_field_len(phase2_len) :
                        cbt_max5(ph1_tq, CBT_PROC_TQ);
  wire [4:0] head_tq = CBT_SYNC_TQ + prop_tq + ph1_tq;
  // a too short setting is padded in phase2 so no bit drops below minimum
  wire [4:0] ph2_floor = (head_tq >= CBT_MIN_BIT_TQ) ? 5'h01 :
                         CBT_MIN_BIT_TQ - head_tq;
  wire [4:0] ph2_tq = cbt_max5(ph2_base, ph2_floor);
  wire [4:0] bit_len_tq = head_tq + ph2_tq;

  // length of the running segment, with any resync adjustment
  wire [4:0] cur_len = (seg == CBT_SEG_SYNC) ? CBT_SYNC_TQ :
                       (seg == CBT_SEG_PROP) ? prop_tq :
                       (seg == CBT_SEG_PH1) ? ph1_tq + ext :
                       ph2_tq - cut;
  wire seg_end = tq_tick && (cnt >= cur_len - 5'h01);

  // recessive to dominant edge on the bus
  wire edge_fall = prev_rx && !can_rx;
  wire hard_now = edge_fall && bus_idle;
  // one resync per bit, never in a hard synced bit or inside sync
  wire resync_ok = edge_fall && !bus_idle && !hard_flag && !resync_done &&
                   (seg != CBT_SEG_SYNC);
  // late edge: phase1 grows by the phase error, capped at the jump width
  wire pos_resync = resync_ok &&
                    ((seg == CBT_SEG_PROP) || (seg == CBT_SEG_PH1));
  // early edge: phase2 shrinks; within reach the bit ends at once
  wire neg_resync = resync_ok && (seg == CBT_SEG_PH2);
  wire [4:0] ph2_rem = ph2_tq - cnt;
  wire jump_now = neg_resync && (ph2_rem <= sjw_tq);
  wire restart = hard_now || jump_now;
  wire wrap_now = seg_end && (seg == CBT_SEG_PH2);
  wire new_bit = wrap_now || jump_now;
  wire sample_now = seg_end && (seg == CBT_SEG_PH1) && !restart;

  // segment sequencer
  wire cbt_seg_t seg_succ = (seg == CBT_SEG_SYNC) ? CBT_SEG_PROP :
                            (seg == CBT_SEG_PROP) ? CBT_SEG_PH1 :
                            (seg == CBT_SEG_PH1) ? CBT_SEG_PH2 :
                            CBT_SEG_SYNC;
  wire cbt_seg_t next_seg = restart ? CBT_SEG_SYNC :
                            seg_end ? seg_succ : seg;
  wire [4:0] next_cnt = restart ? 5'h00 :
                        !tq_tick ? cnt :
                        seg_end ? 5'h00 : cnt + 5'h01;
  wire [4:0] next_pos = restart ? 5'h00 :
                        !tq_tick ? pos :
                        wrap_now ? 5'h00 : pos + 5'h01;
  wire next_hard = hard_now ? 1'b1 : new_bit ? 1'b0 : hard_flag;
  wire next_done = (hard_now || new_bit) ? 1'b0 :
                   resync_ok ? 1'b1 : resync_done;
  wire [4:0] next_ext = (restart || new_bit) ? 5'h00 :
                        pos_resync ? cbt_min5(pos, sjw_tq) : ext;
  wire [4:0] next_cut = (restart || new_bit) ? 5'h00 :
                        neg_resync ? sjw_tq : cut;

  // status word shows the live bit timing state
  wire [31:0] status_word = {19'h0, bit_len_tq, 3'h0, resync_done,
                             hard_flag, bit_value, seg};
  wire [31:0] next_rdata = hit_one ? bit_timing_cfg_one :
                           hit_two ? bit_timing_cfg_two :
                           hit_st ? status_word : 32'h0000_0000;

  // registers take a write only in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_timing_cfg_one <= CBT_CFG_ONE_RST;
      bit_timing_cfg_two <= CBT_CFG_TWO_RST;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_one)
        bit_timing_cfg_one <= pwdata & 32'h0000_01FF;
      if (wr_two)
        bit_timing_cfg_two <= pwdata & 32'h0000_07FF;
      if (apb_setup)
        prdata <= next_rdata;
    end
  end

  // bit sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seg <= CBT_SEG_SYNC;
      cnt <= 5'h00;
      pos <= 5'h00;
      ext <= 5'h00;
      cut <= 5'h00;
      hard_flag <= 1'b0;
      resync_done <= 1'b0;
      prev_rx <= 1'b1;
    end
    else
    begin
      seg <= next_seg;
      cnt <= next_cnt;
      pos <= next_pos;
      ext <= next_ext;
      cut <= next_cut;
      hard_flag <= next_hard;
      resync_done <= next_done;
      prev_rx <= can_rx;
    end
  end

  // event pulses, one cycle after the edge that caused them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_start <= 1'b0;
      sample_point <= 1'b0;
      hard_synced <= 1'b0;
    end
    else
    begin
      bit_start <= restart || wrap_now;
      sample_point <= sample_now;
      hard_synced <= hard_now;
    end
  end

  // quantum ticks; restart realigns the prescaler to the edge
  cbt_quantum_gen #(
    .PRESCALE_W(CBT_PRESCALE_W)
  ) u_quantum (
    .pclk(pclk),
    .presetn(presetn),
    .module_clock_select(module_clock_select),
    .quantum_prescale(quantum_prescale),
    .restart(restart),
    .half_tick(half_tick),
    .tq_tick(tq_tick)
  );

  // bus sampling at the sample point
  cbt_sample_vote u_vote (
    .pclk(pclk),
    .presetn(presetn),
    .half_tick(half_tick),
    .sample_now(sample_now),
    .triple_sample_sel(triple_sample_sel),
    .can_rx(can_rx),
    .bit_value(bit_value),
    .bit_valid(bit_valid)
  );

  a_sync_one_tq: assert property (@(posedge pclk) disable iff (!presetn)
    seg == CBT_SEG_SYNC && tq_tick && !restart |=> seg == CBT_SEG_PROP)
    else $error("sync segment is not one quantum");

  a_seg_order_ok: assert property (@(posedge pclk) disable iff (!presetn)
    seg != $past(seg) |-> seg == CBT_SEG_SYNC ||
      seg == cbt_seg_t'($past(seg) + 2'b01))
    else $error("segments left their order");

  a_sample_ph1_end: assert property (@(posedge pclk) disable iff (!presetn)
    sample_point |-> seg == CBT_SEG_PH2 && $past(seg) == CBT_SEG_PH1)
    else $error("sample not at the end of phase1");

  a_hard_when_idle: assert property (@(posedge pclk) disable iff (!presetn)
    hard_synced |-> $past(bus_idle) && !$past(can_rx) && $past(prev_rx))
    else $error("hard sync without idle falling edge");

  a_hard_restarts: assert property (@(posedge pclk) disable iff (!presetn)
    hard_synced |-> seg == CBT_SEG_SYNC && cnt == 5'h00 && hard_flag)
    else $error("hard sync did not restart the bit");

  a_no_resync_hard: assert property (@(posedge pclk) disable iff (!presetn)
    hard_flag |-> ext == 5'h00 && cut == 5'h00)
    else $error("resync inside a hard synced bit");

  a_jump_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    ext <= sjw_tq && cut <= sjw_tq)
    else $error("phase adjustment beyond jump width");

  a_bit_len_range: assert property (@(posedge pclk) disable iff (!presetn)
    bit_len_tq >= CBT_MIN_BIT_TQ && bit_len_tq <= CBT_MAX_BIT_TQ)
    else $error("nominal bit length out of range");

endmodule : cbt_bit_timing

// ---- testbench/cbt_node_model.sv ----
module cbt_node_model
(
  // clock
  input wire logic pclk,
  // bus side seen by the block
  output logic can_rx,
  output logic bus_idle
);
  timeunit 1ns;
  timeprecision 1ps;

  // the bus is wired-and with a pull to recessive, so it rests at 1
  initial
  begin
    can_rx = 1'b1;
    bus_idle = 1'b1;
  end

  // called just after a rising edge; levels land with that edge's updates
  task automatic drive(input logic lvl, input logic idle);
    can_rx <= lvl;
    bus_idle <= idle;
  endtask : drive

endmodule : cbt_node_model

// ---- testbench/cbt_bit_timing_tb_top.sv ----
module cbt_bit_timing_tb_top
  import cbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // bench-side signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic can_rx, bus_idle, tq_tick, bit_start, sample_point;
  logic hard_synced, bit_value, bit_valid;
  int err_total = 0;
  int n_tests = 0;
  // quantum cases: config one and pclk cycles per quantum
  localparam logic [8:0] QT_CFG [4] = '{9'h000, 9'h003, 9'h03F, 9'h102};
  localparam int QT_LEN [4] = '{2, 8, 128, 24};
  // bit cases: config two, quanta per bit, quanta up to sample
  localparam logic [11:0] BL_CFG [5] = '{12'h191, 12'h3AC, 12'h004,
                                         12'h03F, 12'h080};
  localparam int BL_N [5] = '{8, 16, 9, 25, 8};
  localparam int BL_S [5] = '{6, 12, 7, 17, 3};

  cbt_bit_timing dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
    .bus_idle(bus_idle), .tq_tick(tq_tick), .bit_start(bit_start),
    .sample_point(sample_point), .hard_synced(hard_synced),
    .bit_value(bit_value), .bit_valid(bit_valid)
  );

  cbt_node_model node
  (
    .pclk(pclk),
    .can_rx(can_rx),
    .bus_idle(bus_idle)
  );

  // 20 MHz module clock, well under the 30 MHz ceiling
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ticks(input int k);
    repeat (k) @(posedge pclk);
  endtask : ticks

  // counts edges until a pulse is seen; a stuck design ends the run
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > lim)
      begin
        err_total++;
        complete_run();
      end
    end
    while (s !== 1'b1);
  endtask : wait_hi

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
      if (k > 20)
      begin
        err_total++;
        complete_run();
      end
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_regs();
    apb(1'b0, CBT_ADDR_CFG_ONE, 32'h0, rd, er);
    check(rd, 32'h0000_0000);
    apb(1'b0, CBT_ADDR_CFG_TWO, 32'h0, rd, er);
    check(rd, 32'h0000_0191);
    apb(1'b1, CBT_ADDR_CFG_ONE, 32'hFFFF_FFFF, rd, er);
    apb(1'b0, CBT_ADDR_CFG_ONE, 32'h0, rd, er);
    check(rd, 32'h0000_01FF);
    apb(1'b1, CBT_ADDR_CFG_TWO, 32'hFFFF_FFFF, rd, er);
    apb(1'b0, CBT_ADDR_CFG_TWO, 32'h0, rd, er);
    check(rd, 32'h0000_07FF);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd, er);
    check({31'h0, er}, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0, rd, er);
    check({rd[30:0], er}, 32'h0000_0001);
    apb(1'b1, CBT_ADDR_STATUS, 32'hFFFF_FFFF, rd, er);
    check({31'h0, er}, 32'h0000_0000);
    apb(1'b1, CBT_ADDR_CFG_TWO, 32'h0000_0191, rd, er);
    $display("register test done");
  endtask : t_regs

  task automatic t_quantum();
    int n;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, CBT_ADDR_CFG_ONE, {23'h0, QT_CFG[i]}, rd, er);
      repeat (3) wait_hi(tq_tick, 600, n);
      check(n, QT_LEN[i]);
    end
    $display("quantum test done");
  endtask : t_quantum

  task automatic t_bitlen();
    int n, m;
    // four cycles a quantum keeps every bit at a microsecond or more
    apb(1'b1, CBT_ADDR_CFG_ONE, 32'h0000_0001, rd, er);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, CBT_ADDR_CFG_TWO, {20'h0, BL_CFG[i]}, rd, er);
      repeat (2) wait_hi(bit_start, 400, n);
      wait_hi(sample_point, 400, n);
      wait_hi(bit_start, 400, m);
      check(n, BL_S[i] * 4);
      check(n + m, BL_N[i] * 4);
      apb(1'b0, CBT_ADDR_STATUS, 32'h0, rd, er);
      check({27'h0, rd[12:8]}, BL_N[i]);
    end
    $display("bit length test done");
  endtask : t_bitlen

  // a one-cycle recessive spike right on the sample edge
  task automatic t_triple();
    int n;
    apb(1'b1, CBT_ADDR_CFG_ONE, 32'h0000_0003, rd, er);
    for (int ts = 0; ts < 2; ts++)
    begin
      apb(1'b1, CBT_ADDR_CFG_TWO, 32'h0000_07AC | 32'(ts << 6), rd, er);
      node.drive(1'b0, 1'b0);
      repeat (3) wait_hi(sample_point, 400, n);
      ticks(158);
      node.drive(1'b1, 1'b0);
      ticks(1);
      node.drive(1'b0, 1'b0);
      wait_hi(sample_point, 4, n);
      check({31'h0, bit_value}, {31'h0, ts == 0});
      check({31'h0, bit_valid}, 32'h0000_0001);
    end
    $display("triple sample test done");
  endtask : t_triple

  // phase2 of 8 stays above every jump width; prop plus phase1 is 11
  task automatic t_resync();
    int n;
    // sample point at 12 of 20 quanta, sixty percent into the bit
    apb(1'b1, CBT_ADDR_CFG_TWO, 32'h0000_07AC, rd,
        er);
    for (int j = 0; j < 4; j++)
    begin
      apb(1'b1, CBT_ADDR_CFG_ONE, 32'h0000_0003 | 32'(j << 6), rd, er);
      node.drive(1'b1, 1'b0);
      repeat (2) wait_hi(bit_start, 400, n);
      ticks(44);
      node.drive(1'b0, 1'b0);
      wait_hi(bit_start, 400, n);
      check(n + 44, (21 + j) * 8);
      node.drive(1'b1, 1'b0);
      wait_hi(bit_start, 400, n);
      ticks(100);
      node.drive(1'b0, 1'b0);
      wait_hi(bit_start, 400, n);
      check(n + 100, (19 - j) * 8);
    end
    $display("resync test done");
  endtask : t_resync

  task automatic t_hard();
    int n, k;
    apb(1'b1, CBT_ADDR_CFG_ONE, 32'h0000_0003, rd, er);
    node.drive(1'b1, 1'b1);
    wait_hi(bit_start, 400, n);
    ticks(40);
    node.drive(1'b0, 1'b1);
    wait_hi(hard_synced, 4, n);
    check({31'h0, bit_start}, 32'h0000_0001);
    node.drive(1'b0, 1'b0);
    ticks(16);
    node.drive(1'b1, 1'b0);
    ticks(8);
    node.drive(1'b0, 1'b0);
    wait_hi(bit_start, 400, n);
    check((n + 24 == 160) || (n + 24 == 161), 1);
    node.drive(1'b1, 1'b0);
    ticks(20);
    node.drive(1'b0, 1'b0);
    k = 0;
    repeat (4)
    begin
      @(posedge pclk);
      if (hard_synced === 1'b1)
        k++;
    end
    check(k, 0);
    $display("hard sync test done");
  endtask : t_hard

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_quantum();
    t_bitlen();
    t_triple();
    t_resync();
    t_hard();
    complete_run();
  end

endmodule : cbt_bit_timing_tb_top
